// *** src/ctm_timer.v ***
// Compact 10-bit timer: counter, two comparators, output pins and
// the byte-wide register port with its low-byte holding buffer.
// Assumes one clock; high and sub clocks arrive as enable pulses.
`timescale 1ns/1ps
`include "ctm_regs.vh"

module ctm_timer #(
  parameter CNT_W = 10,                // Counter width
  parameter PER_W = 3                  // Period comparator width
) (
  input wire mclk_i,                   // System clock, 40 MHz
  input wire rst_n_i,                  // Async reset, active low
  input wire clk_h_en_i,               // High clock enable pulse
  input wire clk_sub_en_i,             // Sub clock enable pulse
  input wire ext_clk_i,                // External clock pin level
  input wire [2:0] reg_addr_i,         // Register index
  input wire reg_wr_i,                 // Write strobe, one cycle
  input wire reg_rd_i,                 // Read strobe, one cycle
  input wire [7:0] reg_wdata_i,        // Write data
  output reg [7:0] reg_rdata_o,        // Read data, next cycle
  output wire timer_out_o,             // Primary output pin
  output wire timer_out_n_o,           // Complementary output pin
  output reg match_a_o,                // Comparator A event pulse
  output reg match_p_o                 // Comparator P event pulse
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  reg [1:0] rst_sync_q;                // Two-stage release
  wire rst_n;                          // Internal reset copy

  // Release synchronised so all flops leave reset together
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ---------------------------------------------------------------
  // Registers and fields
  // ---------------------------------------------------------------
  reg [7:0] ctrl_a_q;                  // Control A
  reg [7:0] ctrl_b_q;                  // Control B
  reg [CNT_W-1:0] cmp_a_q;             // Compare A value
  reg [7:0] hold_q;                    // Low-byte holding buffer
  reg [CNT_W-1:0] cnt_q;               // Core counter
  reg on_d1_q;                         // Previous on bit
  reg out_q;                           // Raw output level

  wire pause = ctrl_a_q[`CTM_A_PAUSE];
  wire [2:0] ck_sel = ctrl_a_q[`CTM_A_CKSEL_HI:`CTM_A_CKSEL_LO];
  wire timer_on = ctrl_a_q[`CTM_A_ON];
  wire [PER_W-1:0] period = ctrl_a_q[`CTM_A_PER_HI:`CTM_A_PER_LO];
  wire [1:0] mode = ctrl_b_q[`CTM_B_MODE_HI:`CTM_B_MODE_LO];
  wire [1:0] func = ctrl_b_q[`CTM_B_FUNC_HI:`CTM_B_FUNC_LO];
  wire oc = ctrl_b_q[`CTM_B_OC];
  wire pol = ctrl_b_q[`CTM_B_POL];
  wire dpx = ctrl_b_q[`CTM_B_DPX];
  wire cclr = ctrl_b_q[`CTM_B_CCLR];
  wire on_rise = timer_on & ~on_d1_q;  // Low-to-high of on bit

  // ---------------------------------------------------------------
  // Clock source selection
  // ---------------------------------------------------------------
  reg [5:0] div_sys_q;                 // System clock divider
  reg [5:0] div_h_q;                   // High clock divider
  reg [2:0] ext_q;                     // Sync stages plus history
  reg tick;                            // Selected count enable

  // Dividers produce one-cycle enables for the slow sources
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_sys_q <= 6'h00;
      div_h_q <= 6'h00;
    end else begin
      if (div_sys_q == `CTM_DIV4_LAST) begin
        div_sys_q <= 6'h00;
      end else begin
        div_sys_q <= div_sys_q + 6'h01;
      end
      if (clk_h_en_i) begin
        div_h_q <= div_h_q + 6'h01;
      end
    end
  end

  // External pin: two flops, then one history flop for the edge
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_q <= 3'h0;
    end else begin
      ext_q <= {ext_q[1:0], ext_clk_i};
    end
  end

  // Pick the active edge; only ext_q[1] and ext_q[2] are looked at
  always @* begin
    case (ck_sel)
      `CTM_CK_SYS4: tick = (div_sys_q == `CTM_DIV4_LAST);
      `CTM_CK_SYS: tick = 1'b1;
      `CTM_CK_H16: tick = clk_h_en_i &
        ((div_h_q & `CTM_DIV16_LAST) == `CTM_DIV16_LAST);
      `CTM_CK_H64: tick = clk_h_en_i & (div_h_q == `CTM_DIV64_LAST);
      `CTM_CK_SUB0: tick = clk_sub_en_i;
      `CTM_CK_SUB1: tick = clk_sub_en_i;
      `CTM_CK_EXTR: tick = ext_q[1] & ~ext_q[2];
      `CTM_CK_EXTF: tick = ~ext_q[1] & ext_q[2];
      default: tick = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Comparators
  // ---------------------------------------------------------------
  wire run = timer_on & ~pause & tick;
  wire is_pwm = (mode == `CTM_MODE_PWM);
  // P compares the top bits with period and the low bits with zero; zero period means full wrap
  wire p_eq = (cnt_q[CNT_W-1:CNT_W-PER_W] == period) &
    (cnt_q[CNT_W-PER_W-1:0] == {(CNT_W-PER_W){1'b0}});
  wire a_eq = (cnt_q == cmp_a_q);
  wire cnt_max = &cnt_q;               // Overflow point
  wire p_hit = run & (period != {PER_W{1'b0}}) &
    (cnt_q[CNT_W-1:CNT_W-PER_W] == period - {{(PER_W-1){1'b0}}, 1'b1}) &
    (&cnt_q[CNT_W-PER_W-1:0]);
  wire a_hit = run & (cnt_q + {{(CNT_W-1){1'b0}}, 1'b1} == cmp_a_q) &
    (cmp_a_q != {CNT_W{1'b0}});
  reg clr_now;                         // Counter clears this tick

  // Clear source: P or overflow, or A; in PWM the period owner
  always @* begin
    if (is_pwm) begin
      clr_now = dpx ? a_hit : (p_hit | (run & cnt_max));
    end else if (cclr) begin
      clr_now = a_hit;
    end else begin
      clr_now = p_hit | (run & cnt_max);
    end
  end

  // Counter: software only clears it via the on-bit rise
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= {CNT_W{1'b0}};
      on_d1_q <= 1'b0;
    end else begin
      on_d1_q <= timer_on;
      if (on_rise) begin
        cnt_q <= {CNT_W{1'b0}};
      end else if (clr_now) begin
        cnt_q <= {CNT_W{1'b0}};
      end else if (run) begin
        cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Event pulses, one cycle per match; no P event when cclr has A clear outside PWM
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      match_a_o <= 1'b0;
      match_p_o <= 1'b0;
    end else begin
      match_a_o <= a_hit;
      // Period zero: the overflow wrap stands in for the P event
      match_p_o <= (p_hit | (run & cnt_max &
        (period == {PER_W{1'b0}}))) & (is_pwm | ~cclr);
    end
  end

  // ---------------------------------------------------------------
  // Output logic
  // ---------------------------------------------------------------
  // PWM duty compare: active while below the duty owner's value
  wire [CNT_W-1:0] duty_val = dpx ?
    {period, {(CNT_W-PER_W){1'b0}}} : cmp_a_q;
  wire pwm_act = (cnt_q < duty_val);
  reg pin_raw;                         // Level before polarity

  // Compare mode acts on A only; level requests may be no-ops
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b0;
    end else if (on_rise) begin
      out_q <= oc;
    end else if (mode == `CTM_MODE_CMP && a_hit) begin
      case (func)
        `CTM_FN_NONE: out_q <= out_q;
        `CTM_FN_LOW: out_q <= 1'b0;
        `CTM_FN_LOW2: out_q <= 1'b0;
        `CTM_FN_TOG: out_q <= ~out_q;
        default: out_q <= out_q;
      endcase
    end
  end

  // Mode chooses the source; timer mode parks the pin low
  always @* begin
    case (mode)
      `CTM_MODE_CMP: pin_raw = out_q;
      `CTM_MODE_PWM: begin
        case (func)
          `CTM_FN_NONE: pin_raw = ~oc;
          `CTM_FN_LOW: pin_raw = oc;
          `CTM_FN_PWM: pin_raw = timer_on & pwm_act ? oc : ~oc;
          default: pin_raw = ~oc;
        endcase
      end
      default: pin_raw = 1'b0;
    endcase
  end

  // Polarity ignored in timer mode, where the pin is unused
  wire pin_pol = (mode == `CTM_MODE_TC) ? 1'b0 : pin_raw ^ pol;
  assign timer_out_o = pin_pol;
  assign timer_out_n_o = ~pin_pol;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  // Writes; the holding buffer is shared by both byte pairs
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_a_q <= `CTM_RST_CTRL;
      ctrl_b_q <= `CTM_RST_CTRL;
      cmp_a_q <= {CNT_W{1'b0}};
      hold_q <= 8'h00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `CTM_IDX_CTRL_A: ctrl_a_q <= reg_wdata_i;
        `CTM_IDX_CTRL_B: ctrl_b_q <= reg_wdata_i;
        `CTM_IDX_CMP_LO: hold_q <= reg_wdata_i;
        `CTM_IDX_CMP_HI: cmp_a_q <=
          {reg_wdata_i[CNT_W-9:0], hold_q};
        default: hold_q <= hold_q;     // Counter is read-only
      endcase
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `CTM_IDX_CNT_HI: hold_q <= cnt_q[7:0];
        `CTM_IDX_CMP_HI: hold_q <= cmp_a_q[7:0];
        default: hold_q <= hold_q;
      endcase
    end
  end

  // Read data; low bytes come from the buffer, unused bits zero
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `CTM_IDX_CTRL_A: reg_rdata_o <= ctrl_a_q;
        `CTM_IDX_CTRL_B: reg_rdata_o <= ctrl_b_q;
        `CTM_IDX_CNT_LO: reg_rdata_o <= hold_q;
        `CTM_IDX_CNT_HI: reg_rdata_o <=
          {{(16-CNT_W){1'b0}}, cnt_q[CNT_W-1:8]};
        `CTM_IDX_CMP_LO: reg_rdata_o <= hold_q;
        `CTM_IDX_CMP_HI: reg_rdata_o <=
          {{(16-CNT_W){1'b0}}, cmp_a_q[CNT_W-1:8]};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

endmodule

// *** src/ctm_regs.vh ***
// Register indices, field positions and timing constants of the timer.
// Assumes inclusion by the timer core only; definitions, no logic.
`ifndef CTM_REGS_VH
`define CTM_REGS_VH

// ---------------------------------------------------------------
// Register indices (chosen, documentation prints none)
// ---------------------------------------------------------------
`define CTM_IDX_CTRL_A 3'h0
`define CTM_IDX_CTRL_B 3'h1
`define CTM_IDX_CNT_LO 3'h2
`define CTM_IDX_CNT_HI 3'h3
`define CTM_IDX_CMP_LO 3'h4
`define CTM_IDX_CMP_HI 3'h5

// ---------------------------------------------------------------
// Control A fields
// ---------------------------------------------------------------
`define CTM_A_PAUSE 7
`define CTM_A_CKSEL_HI 6
`define CTM_A_CKSEL_LO 4
`define CTM_A_ON 3
`define CTM_A_PER_HI 2
`define CTM_A_PER_LO 0

// ---------------------------------------------------------------
// Control B fields
// ---------------------------------------------------------------
`define CTM_B_MODE_HI 7
`define CTM_B_MODE_LO 6
`define CTM_B_FUNC_HI 5
`define CTM_B_FUNC_LO 4
`define CTM_B_OC 3
`define CTM_B_POL 2
`define CTM_B_DPX 1
`define CTM_B_CCLR 0

// ---------------------------------------------------------------
// Reset values and encodings
// ---------------------------------------------------------------
`define CTM_RST_CTRL 8'h00
`define CTM_MODE_CMP 2'h0
`define CTM_MODE_PWM 2'h2
`define CTM_MODE_TC 2'h3
`define CTM_CK_SYS4 3'h0
`define CTM_CK_SYS 3'h1
`define CTM_CK_H16 3'h2
`define CTM_CK_H64 3'h3
`define CTM_CK_SUB0 3'h4
`define CTM_CK_SUB1 3'h5
`define CTM_CK_EXTR 3'h6
`define CTM_CK_EXTF 3'h7
`define CTM_FN_NONE 2'h0
`define CTM_FN_LOW 2'h1
`define CTM_FN_LOW2 2'h2
`define CTM_FN_TOG 2'h3
`define CTM_FN_PWM 2'h2

// ---------------------------------------------------------------
// Divider terminal counts
// ---------------------------------------------------------------
`define CTM_DIV4_LAST 6'h03
`define CTM_DIV16_LAST 6'h0F
`define CTM_DIV64_LAST 6'h3F

`endif

// *** verification/ctm_timer_checker.sv ***
// Concurrent checks on the compact timer's top-level ports.
// Assumes binding to ctm_timer; control bytes are shadowed from writes.
`timescale 1ns/1ps
module ctm_timer_checker #(
  parameter CNT_W = 10, // Counter width
  parameter PER_W = 3 // Period comparator width
) (
  input wire mclk_i, // System clock
  input wire rst_n_i, // Reset, active low
  input wire [2:0] reg_addr_i, // Register index
  input wire reg_wr_i, // Write strobe
  input wire reg_rd_i, // Read strobe
  input wire [7:0] reg_wdata_i, // Write data
  input wire [7:0] reg_rdata_o, // Read data
  input wire timer_out_o, // Primary pin
  input wire timer_out_n_o, // Inverted pin
  input wire match_a_o, // Comparator A event
  input wire match_p_o // Comparator P event
);
  // ------------------------------------------------------------
  // Control shadows
  // ------------------------------------------------------------
  reg [7:0] ctl_a_q; // Copy of control A
  reg [7:0] ctl_b_q; // Copy of control B

  // Track control writes; write wins over a read
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_a_q <= 8'h00;
      ctl_b_q <= 8'h00;
    end else if (reg_wr_i && reg_addr_i == 3'h0) begin
      ctl_a_q <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == 3'h1) begin
      ctl_b_q <= reg_wdata_i;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_pin_complement: assert property (timer_out_n_o == !timer_out_o)
    else $error("complementary pin equals primary pin");
  a_match_a_pulse: assert property (match_a_o |=> !match_a_o)
    else $error("comparator A event longer than one cycle");
  a_match_p_pulse: assert property (match_p_o |=> !match_p_o)
    else $error("comparator P event longer than one cycle");
  a_rdata_stands: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  a_high_read_zero: assert property (reg_rd_i && !reg_wr_i &&
    (reg_addr_i == 3'h3 || reg_addr_i == 3'h5) |=> reg_rdata_o[7:2] == 6'h00)
    else $error("high byte read shows upper bits set");
  a_unmapped_zero: assert property (reg_rd_i && !reg_wr_i &&
    reg_addr_i > 3'h5 |=> reg_rdata_o == 8'h00)
    else $error("unmapped read returned nonzero");
  a_tc_pin_low: assert property ($stable(ctl_b_q) &&
    ctl_b_q[7:6] == 2'h3 |-> !timer_out_o)
    else $error("pin driven in timer mode");
  a_on_rise_init: assert property (reg_wr_i && reg_addr_i == 3'h0 &&
    reg_wdata_i[3] && !ctl_a_q[3] && ctl_b_q[7:6] == 2'h0
    |-> ##[1:2] timer_out_o == (ctl_b_q[3] ^ ctl_b_q[2]))
    else $error("pin not at initial level after start");
  a_off_quiet: assert property ((!ctl_a_q[3]) [*3]
    |-> !match_a_o && !match_p_o)
    else $error("match event while timer off");
  a_cclr_no_p: assert property ((ctl_b_q[0] && ctl_b_q[7:6] == 2'h0) [*3]
    |-> !match_p_o)
    else $error("P event while A match clears");
endmodule

// *** verification/testbench.sv ***
// Self-checking bench: register port, clock sources, periods, pin
// actions, pause and on/off. Assumes ctm_timer and its checker.
`timescale 1ns/1ps
module testbench;
  reg mclk_i = 1'b0; // System clock
  reg rst_n_i = 1'b0; // Reset, active low
  reg clk_h_en_i = 1'b1; // High clock equals system clock
  reg clk_sub_en_i = 1'b0; // Sub clock, every other cycle
  reg ext_clk_i = 1'b0; // External pin, period 8 cycles
  reg [2:0] cyc = 3'h0; // Pattern counter for the pin
  reg [2:0] reg_addr_i = 3'h0; // Register index
  reg reg_wr_i = 1'b0; // Write strobe
  reg reg_rd_i = 1'b0; // Read strobe
  reg [7:0] reg_wdata_i = 8'h00; // Write data
  wire [7:0] reg_rdata_o; // Read data
  wire timer_out_o; // Primary pin
  wire timer_out_n_o; // Inverted pin
  wire match_a_o; // A event
  wire match_p_o; // P event
  integer err_count = 0; // Mismatches
  integer n_checks = 0; // Comparisons
  integer n; // Cycles to a pulse
  integer i; // Loop index
  reg [15:0] c1; // Counter snapshots
  reg [15:0] c2;
  reg [9:0] tab [0:8]; // Control B, initial pin, pin after match

  ctm_timer dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .clk_h_en_i(clk_h_en_i), .clk_sub_en_i(clk_sub_en_i),
    .ext_clk_i(ext_clk_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .timer_out_o(timer_out_o),
    .timer_out_n_o(timer_out_n_o), .match_a_o(match_a_o),
    .match_p_o(match_p_o));

  // 40 MHz clock
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  // Slow sources; fixed ratios keep expected periods exact
  always @(posedge mclk_i) begin
    clk_sub_en_i <= #1 ~clk_sub_en_i;
    cyc <= #1 cyc + 3'h1;
    ext_clk_i <= #1 cyc[2];
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask

  // Register write; entry waits an edge so strobes never abut
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge mclk_i);
      #1 reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(posedge mclk_i);
      #1 reg_wr_i = 1'b0;
    end
  endtask

  task rd(input [2:0] a, output [7:0] d);
    begin
      @(posedge mclk_i);
      #1 reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(posedge mclk_i);
      #1 reg_rd_i = 1'b0;
      @(posedge mclk_i);
      #1 d = reg_rdata_o;
    end
  endtask

  // High byte first so the low byte comes from the holding buffer
  task rd16(input [2:0] hi, output [15:0] v);
    begin
      rd(hi, v[15:8]);
      rd(hi - 3'h1, v[7:0]);
    end
  endtask

  // Cycles until the chosen event, bounded
  task wp(input sel_a, output integer cnt);
    begin
      cnt = 0;
      do begin
        @(posedge mclk_i);
        #1 cnt = cnt + 1;
      end while ((sel_a ? match_a_o : match_p_o) !== 1'b1 && cnt < 20000);
      if (cnt >= 20000) chk(16'h0001, 16'h0000);
    end
  endtask

  function integer div_of(input [2:0] s);
    case (s)
      3'h0: div_of = 4;
      3'h2: div_of = 16;
      3'h3: div_of = 64;
      3'h4, 3'h5: div_of = 2;
      3'h6, 3'h7: div_of = 8;
      default: div_of = 1;
    endcase
  endfunction

  // Restart the timer and time one full P period
  task measure(input [2:0] s, input [2:0] p);
    begin
      wr(3'h0, 8'h00);
      wr(3'h0, {1'b0, s, 1'b1, p});
      wp(1'b0, n);
      wp(1'b0, n);
      chk(n[15:0], 16'(div_of(s) * (p == 3'h0 ? 1024 : p * 128)));
    end
  endtask

  task end_of_test;
    begin
      $display("checks=%0d errors=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task t_regs;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        rd(i[2:0], c1[7:0]);
        chk({8'h00, c1[7:0]}, 16'h0000);
      end
      wr(3'h4, 8'hA5);
      wr(3'h5, 8'h03);
      rd16(3'h5, c1);
      chk(c1, 16'h03A5);
      wr(3'h3, 8'hFF);
      wr(3'h2, 8'hFF);
      rd16(3'h3, c1);
      chk(c1, 16'h0000);
    end
  endtask

  task t_outputs;
    begin
      tab[0] = {8'h31, 2'b01}; tab[1] = {8'h3D, 2'b01};
      tab[2] = {8'h19, 2'b10}; tab[3] = {8'h11, 2'b00};
      tab[4] = {8'h0D, 2'b00}; tab[5] = {8'h29, 2'b10};
      tab[6] = {8'h88, 2'b00}; tab[7] = {8'h98, 2'b11};
      tab[8] = {8'hF9, 2'b00};
      wr(3'h4, 8'h0A);
      wr(3'h5, 8'h00);
      for (i = 0; i < 9; i = i + 1) begin
        wr(3'h0, 8'h00);
        wr(3'h1, tab[i][9:2]);
        wr(3'h0, 8'h19);
        repeat (3) @(posedge mclk_i);
        #1;
        chk({15'h0, timer_out_o}, {15'h0, tab[i][1]});
        wp(1'b1, n);
        repeat (2) @(posedge mclk_i);
        #1;
        chk({15'h0, timer_out_o}, {15'h0, tab[i][0]});
      end
    end
  endtask

  task t_pause;
    begin
      wr(3'h1, 8'h00);
      wr(3'h0, 8'h00);
      wr(3'h0, 8'h18);
      repeat (40) @(posedge mclk_i);
      wr(3'h0, 8'h98);
      rd16(3'h3, c1);
      repeat (30) @(posedge mclk_i);
      rd16(3'h3, c2);
      chk(c2, c1);
      wr(3'h0, 8'h18);
      rd16(3'h3, c2);
      chk({15'h0, c2 > c1 && c2 < c1 + 16'h0010}, 16'h0001);
      wr(3'h0, 8'h10);
      rd16(3'h3, c1);
      repeat (20) @(posedge mclk_i);
      rd16(3'h3, c2);
      chk(c2, c1);
      wr(3'h0, 8'h18);
      rd16(3'h3, c2);
      chk({15'h0, c2 < 16'h0010 && c1 > 16'h0020}, 16'h0001);
    end
  endtask

  // Main sequence
  initial begin
    repeat (20) @(posedge mclk_i);
    #1 rst_n_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    t_regs;
    for (i = 0; i < 8; i = i + 1) begin
      measure(i[2:0], 3'h1);
    end
    measure(3'h1, 3'h0);
    measure(3'h1, 3'h7);
    t_outputs;
    t_pause;
    end_of_test;
  end

  // Watchdog, well past the expected run
  initial begin
    #(25 * 60000);
    err_count = err_count + 1;
    end_of_test;
  end
endmodule

bind ctm_timer ctm_timer_checker #(.CNT_W(CNT_W), .PER_W(PER_W)) chk_u (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .timer_out_o(timer_out_o),
  .timer_out_n_o(timer_out_n_o), .match_a_o(match_a_o),
  .match_p_o(match_p_o));
